/* tsf_consts.svh */
// Constants of the three-stage reading filter: offsets, field positions,
// reset values, limits and automatic-selection figures.
// Assumes inclusion by name from the package and the filter module.
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the 8-bit register port)
// ----------------------------------------------------------------
`define TSF_OFF_CTRL      8'h00
`define TSF_OFF_REP_COUNT 8'h04
`define TSF_OFF_MED_RANK  8'h08
`define TSF_OFF_MOV_COUNT 8'h0C
`define TSF_OFF_WINDOW    8'h10
`define TSF_OFF_STATUS    8'h14

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define TSF_CTRL_AUTO 0
`define TSF_CTRL_REP  1
`define TSF_CTRL_MED  2
`define TSF_CTRL_MOV  3
`define TSF_CTRL_WIN  4

// ----------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------
`define TSF_STAT_REP_LSB  0
`define TSF_STAT_RANK_LSB 8
`define TSF_STAT_MOV_LSB  16
`define TSF_STAT_YIELD    24
`define TSF_STAT_MOVRUN   25

// ----------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------
`define TSF_MAX_COUNT   7'h64
`define TSF_MIN_COUNT   7'h01
`define TSF_MAX_RANK    3'h5
`define TSF_MAX_WINDOW  7'h69
`define TSF_PCT_SCALE   40'h00_0000_0064
`define TSF_MED_DEPTH   11
`define TSF_MOV_DEPTH   100
`define TSF_RST_COUNT   7'h01
`define TSF_RST_RANK    3'h0
`define TSF_RST_WINDOW  7'h00

// ----------------------------------------------------------------
// Automatic selection: line-cycle tiers in hundredths, table values
// ----------------------------------------------------------------
`define TSF_LC_TIER0_MAX 10'h00A
`define TSF_LC_TIER1_MAX 10'h064
`define TSF_TIER0_REP_TOP 4'h6
`define TSF_TIER1_REP_TOP 4'h3
`define TSF_AUTO_REP      7'h0A
`define TSF_AUTO_RANK0    3'h5
`define TSF_AUTO_RANK1    3'h3
`define TSF_AUTO_RANK2    3'h1
`define TSF_AUTO_MOV0     7'h22
`define TSF_AUTO_MOV1     7'h0F
`define TSF_AUTO_MOV2_T0  7'h0A
`define TSF_AUTO_MOV_LOW  7'h05

`endif

/* tsf_pkg.sv */
// Types shared by the three-stage reading filter.
// Assumes tsf_consts.svh is on the include path.
`default_nettype none
`include "tsf_consts.svh"

package tsf_pkg;

	// Signed reading as produced by the converter sequencer
	typedef logic signed [31:0] tsf_reading_t;

	// Stack fill state, Gray ordered
	typedef enum logic [0:0]
	{
		FS_EMPTY = 1'b0,
		FS_RUN   = 1'b1
	} tsf_fill_t;

	// Counts and rank chosen by automatic selection
	typedef struct packed
	{
		logic [6:0] rep;
		logic [2:0] rank;
		logic [6:0] mov;
	} tsf_sel_t;

endpackage

`default_nettype wire

/* tsf_filter.sv */
// Three-stage reading filter: repeat average, running median, moving
// average with noise-window bypass, plus automatic count selection.
// Assumes converter, sweep and range inputs come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"

module tsf_filter
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	input  wire logic                  conv_valid,
	input  wire tsf_pkg::tsf_reading_t conv_data,
	input  wire logic                  sweep_active,
	input  wire logic                  source_step,
	input  wire logic [3:0]            source_range,
	input  wire logic [3:0]            measure_range,
	input  wire logic [31:0]           range_full_scale,
	input  wire logic [9:0]            integration_line_cycles,
	output logic                       reading_valid,
	output tsf_pkg::tsf_reading_t      reading_data,
	output logic                       range_change_ok
);
	import tsf_pkg::*;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic                   auto_en;
		logic                   rep_en;
		logic                   med_en;
		logic                   mov_en;
		logic                   win_en;
		logic [6:0]             rep_cnt;
		logic [2:0]             rank;
		logic [6:0]             mov_cnt;
		logic [6:0]             win_pct;
		logic [31:0]            rd_data;
		logic [3:0]             src_rng;
		logic [3:0]             meas_rng;
		logic [6:0]             eff_rep;
		logic [2:0]             eff_rank;
		logic [6:0]             eff_mov;
		logic [6:0]             rep_n;
		logic signed [38:0]     rep_sum;
		logic                   s1_v;
		tsf_reading_t           s1_data;
		logic [10:0][31:0]      med_mem;
		logic [3:0]             med_fill;
		logic [3:0]             med_wp;
		tsf_fill_t              med_st;
		logic                   med_yield;
		logic                   s2_v;
		tsf_reading_t           s2_data;
		logic [99:0][31:0]      mov_mem;
		logic [6:0]             mov_wp;
		logic signed [38:0]     mov_sum;
		tsf_fill_t              mov_st;
		tsf_reading_t           mov_prev;
		logic                   out_v;
		tsf_reading_t           out_data;
	} tsf_state_t;

	tsf_state_t q;
	tsf_state_t d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Count clamp into 1..100
	function automatic logic [6:0] clamp_cnt(input logic [31:0] v);
		logic [6:0] r;
		r = v[6:0];
		if (v == 32'h0000_0000)
			r = `TSF_MIN_COUNT;
		else if (v > {25'h000_0000, `TSF_MAX_COUNT})
			r = `TSF_MAX_COUNT;
		return r;
	endfunction

	// Automatic selection table by range index and line cycles
	function automatic tsf_sel_t auto_sel(input logic [3:0] rng, input logic [9:0] lc);
		tsf_sel_t s;
		s.rep  = `TSF_MIN_COUNT;
		s.rank = 3'h0;
		s.mov  = `TSF_MIN_COUNT;
		if (lc <= `TSF_LC_TIER0_MAX)
		begin
			if (rng <= `TSF_TIER0_REP_TOP)
				s.rep = `TSF_AUTO_REP;
		end
		else if (lc <= `TSF_LC_TIER1_MAX)
		begin
			if (rng <= `TSF_TIER1_REP_TOP)
				s.rep = `TSF_AUTO_REP;
		end
		unique case (rng)
			4'h0:
			begin
				s.rank = `TSF_AUTO_RANK0;
				s.mov  = `TSF_AUTO_MOV0;
			end
			4'h1:
			begin
				s.rank = `TSF_AUTO_RANK1;
				s.mov  = `TSF_AUTO_MOV1;
			end
			4'h2:
			begin
				s.rank = `TSF_AUTO_RANK2;
				s.mov  = (lc <= `TSF_LC_TIER0_MAX) ? `TSF_AUTO_MOV2_T0 : `TSF_AUTO_MOV_LOW;
			end
			4'h3:
				s.mov  = `TSF_AUTO_MOV_LOW;
			default:
				s.mov  = `TSF_MIN_COUNT;
		endcase
		return s;
	endfunction

	// Middle value of the first m entries, ties broken by slot
	function automatic tsf_reading_t med_pick(input logic [10:0][31:0] a, input logic [3:0] m,
		input logic [2:0] r);
		tsf_reading_t res;
		logic [3:0]   lt;
		res = a[0];
		for (int i = 0; i < `TSF_MED_DEPTH; i++)
		begin
			lt = 4'h0;
			for (int j = 0; j < `TSF_MED_DEPTH; j++)
			begin
				if (4'(j) < m && ($signed(a[j]) < $signed(a[i]) || (a[j] == a[i] && j < i)))
					lt = lt + 4'h1;
			end
			if (4'(i) < m && lt == {1'b0, r})
				res = a[i];
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		tsf_sel_t           a;
		logic               flush;
		logic               e_win;
		logic [3:0]         m_len;
		logic signed [38:0] sum_n;
		logic signed [38:0] x_ext;
		logic signed [32:0] diff;
		logic [39:0]        dev;
		logic [39:0]        lim;
		logic [10:0][31:0]  mwin;
		a     = auto_sel(measure_range, integration_line_cycles);
		flush = 1'b0;
		e_win = 1'b0;
		m_len = 4'h0;
		sum_n = 39'sh0;
		x_ext = 39'sh0;
		diff  = 33'sh0;
		dev   = 40'h00_0000_0000;
		lim   = 40'h00_0000_0000;
		mwin  = q.med_mem;
		d     = q;

		// Register writes
		if (reg_wr)
		begin
			unique case (reg_addr)
				`TSF_OFF_CTRL:
				begin
					d.auto_en = reg_wdata[`TSF_CTRL_AUTO];
					if (!q.auto_en)
					begin
						d.rep_en = reg_wdata[`TSF_CTRL_REP];
						d.med_en = reg_wdata[`TSF_CTRL_MED];
						d.mov_en = reg_wdata[`TSF_CTRL_MOV];
						d.win_en = reg_wdata[`TSF_CTRL_WIN];
					end
					if (reg_wdata[`TSF_CTRL_AUTO])
						d.win_en = 1'b0;
					else if (q.auto_en)
					begin
						d.rep_cnt = q.eff_rep;
						d.rank    = q.eff_rank;
						d.mov_cnt = q.eff_mov;
						d.rep_en  = 1'b1;
						d.med_en  = 1'b1;
						d.mov_en  = 1'b1;
					end
				end
				`TSF_OFF_REP_COUNT:
					if (!q.auto_en)
						d.rep_cnt = clamp_cnt(reg_wdata);
				`TSF_OFF_MED_RANK:
					if (!q.auto_en)
						d.rank = (reg_wdata > 32'h0000_0005) ? `TSF_MAX_RANK : reg_wdata[2:0];
				`TSF_OFF_MOV_COUNT:
					if (!q.auto_en)
						d.mov_cnt = clamp_cnt(reg_wdata);
				`TSF_OFF_WINDOW:
					d.win_pct = (reg_wdata > 32'h0000_0069) ? `TSF_MAX_WINDOW : reg_wdata[6:0];
				default:
					d.rd_data = q.rd_data;
			endcase
		end

		// Register reads, data valid the next cycle only
		d.rd_data = 32'h0000_0000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`TSF_OFF_CTRL:
					d.rd_data = {27'h000_0000, q.win_en, q.mov_en, q.med_en, q.rep_en, q.auto_en};
				`TSF_OFF_REP_COUNT:
					d.rd_data = {25'h000_0000, q.rep_cnt};
				`TSF_OFF_MED_RANK:
					d.rd_data = {29'h0000_0000, q.rank};
				`TSF_OFF_MOV_COUNT:
					d.rd_data = {25'h000_0000, q.mov_cnt};
				`TSF_OFF_WINDOW:
					d.rd_data = {25'h000_0000, q.win_pct};
				`TSF_OFF_STATUS:
				begin
					d.rd_data[`TSF_STAT_REP_LSB +: 7]  = q.eff_rep;
					d.rd_data[`TSF_STAT_RANK_LSB +: 3] = q.eff_rank;
					d.rd_data[`TSF_STAT_MOV_LSB +: 7]  = q.eff_mov;
					d.rd_data[`TSF_STAT_YIELD]         = q.med_yield;
					d.rd_data[`TSF_STAT_MOVRUN]        = (q.mov_st == FS_RUN);
				end
				default:
					d.rd_data = 32'h0000_0000;
			endcase
		end

		// Effective settings, a count of one or a rank of zero means bypass
		d.eff_rep  = q.auto_en ? a.rep  : (q.rep_en ? q.rep_cnt : `TSF_MIN_COUNT);
		d.eff_rank = q.auto_en ? a.rank : (q.med_en ? q.rank : 3'h0);
		d.eff_mov  = q.auto_en ? a.mov  : (q.mov_en ? q.mov_cnt : `TSF_MIN_COUNT);
		e_win      = q.win_en && !q.auto_en;
		m_len      = {q.eff_rank, 1'b1};

		// Flush on sweep step, range change or new settings
		d.src_rng  = source_range;
		d.meas_rng = measure_range;
		flush = (source_step && sweep_active)
			|| (source_range != q.src_rng) || (measure_range != q.meas_rng)
			|| (d.eff_rep != q.eff_rep) || (d.eff_rank != q.eff_rank) || (d.eff_mov != q.eff_mov);

		// Stage 1: repeat average on raw conversions
		d.s1_v = 1'b0;
		x_ext  = 39'(conv_data);
		if (flush)
		begin
			d.rep_n   = 7'h00;
			d.rep_sum = 39'sh0;
		end
		else if (conv_valid)
		begin
			if (q.eff_rep == `TSF_MIN_COUNT)
			begin
				d.s1_v    = 1'b1;
				d.s1_data = conv_data;
			end
			else
			begin
				sum_n = q.rep_sum + x_ext;
				if (q.rep_n + 7'h01 == q.eff_rep)
				begin
					d.s1_v    = 1'b1;
					d.s1_data = 32'(sum_n / $signed({32'h0000_0000, q.eff_rep}));
					d.rep_n   = 7'h00;
					d.rep_sum = 39'sh0;
				end
				else
				begin
					d.rep_n   = q.rep_n + 7'h01;
					d.rep_sum = sum_n;
				end
			end
		end

		// Stage 2: running median on repeat output
		d.s2_v = 1'b0;
		if (flush)
		begin
			d.med_fill  = 4'h0;
			d.med_wp    = 4'h0;
			d.med_st    = FS_EMPTY;
			d.med_yield = 1'b0;
		end
		else if (q.s1_v)
		begin
			if (q.eff_rank == 3'h0)
			begin
				d.s2_v    = 1'b1;
				d.s2_data = q.s1_data;
			end
			else
			begin
				mwin[q.med_wp] = q.s1_data;
				d.med_mem      = mwin;
				d.med_wp       = (q.med_wp + 4'h1 == m_len) ? 4'h0 : q.med_wp + 4'h1;
				if (q.med_st == FS_RUN || q.med_fill + 4'h1 == m_len)
				begin
					d.med_st    = FS_RUN;
					d.med_yield = 1'b1;
					d.s2_v      = 1'b1;
					d.s2_data   = med_pick(mwin, m_len, q.eff_rank);
				end
				else
					d.med_fill = q.med_fill + 4'h1;
			end
		end

		// Stage 3: moving average with noise window
		d.out_v = 1'b0;
		x_ext   = 39'(q.s2_data);
		diff    = 33'(q.s2_data) - 33'(q.mov_prev);
		dev     = 40'(diff[32] ? -diff : diff) * `TSF_PCT_SCALE;
		lim     = 40'(range_full_scale) * 40'(q.win_pct);
		if (flush)
			d.mov_st = FS_EMPTY;
		else if (q.s2_v)
		begin
			d.out_v    = 1'b1;
			d.mov_prev = q.s2_data;
			if (q.eff_mov == `TSF_MIN_COUNT)
				d.out_data = q.s2_data;
			else
			begin
				unique case (q.mov_st)
					FS_EMPTY:
					begin
						for (int i = 0; i < `TSF_MOV_DEPTH; i++)
							d.mov_mem[i] = q.s2_data;
						d.mov_sum  = x_ext * $signed({32'h0000_0000, q.eff_mov});
						d.mov_wp   = 7'h01;
						d.mov_st   = FS_RUN;
						d.out_data = q.s2_data;
					end
					FS_RUN:
					begin
						if (e_win && dev > lim)
						begin
							for (int i = 0; i < `TSF_MOV_DEPTH; i++)
								d.mov_mem[i] = q.s2_data;
							d.mov_sum  = x_ext * $signed({32'h0000_0000, q.eff_mov});
							d.mov_wp   = (q.eff_mov == 7'h02) ? 7'h00 : 7'h01;
							d.out_data = q.s2_data;
						end
						else
						begin
							sum_n = q.mov_sum - 39'($signed(q.mov_mem[q.mov_wp])) + x_ext;
							d.mov_mem[q.mov_wp] = q.s2_data;
							d.mov_sum  = sum_n;
							d.mov_wp   = (q.mov_wp + 7'h01 == q.eff_mov) ? 7'h00 : q.mov_wp + 7'h01;
							d.out_data = 32'(sum_n / $signed({32'h0000_0000, q.eff_mov}));
						end
					end
				endcase
				if (q.mov_st == FS_EMPTY && q.eff_mov == 7'h02)
					d.mov_wp = 7'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			q          <= '0;
			q.rep_cnt  <= `TSF_RST_COUNT;
			q.rank     <= `TSF_RST_RANK;
			q.mov_cnt  <= `TSF_RST_COUNT;
			q.win_pct  <= `TSF_RST_WINDOW;
			q.eff_rep  <= `TSF_RST_COUNT;
			q.eff_mov  <= `TSF_RST_COUNT;
			q.med_st   <= FS_EMPTY;
			q.mov_st   <= FS_EMPTY;
		end
		else
			q <= d;
	end

	// Outputs from the state record; range_change_ok decoded from med_yield and eff_rank
	assign reg_rdata       = q.rd_data;
	assign reading_valid   = q.out_v;
	assign reading_data    = q.out_data;
	assign range_change_ok = q.med_yield || (q.eff_rank == 3'h0);

endmodule

`default_nettype wire

/* tsf_filter_props.sv */
// Port checker for the three-stage reading filter.
// Assumes it is bound onto tsf_filter and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"

module tsf_filter_chk
(
	input wire logic                  clk,
	input wire logic                  reset,
	input wire logic [7:0]            reg_addr,
	input wire logic                  reg_rd,
	input wire logic [31:0]           reg_rdata,
	input wire logic                  conv_valid,
	input wire logic                  sweep_active,
	input wire logic                  source_step,
	input wire logic [3:0]            source_range,
	input wire logic [3:0]            measure_range,
	input wire logic                  reading_valid,
	input wire tsf_pkg::tsf_reading_t reading_data
);
	import tsf_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// -------------------------------------------
	// Triggers
	// -------------------------------------------
	sequence stat_read;
		reg_rd && reg_addr == `TSF_OFF_STATUS;
	endsequence
	sequence sweep_cut;
		source_step && sweep_active;
	endsequence

	// -------------------------------------------
	// Properties
	// -------------------------------------------
	chk_rdata_idle_zero:
		assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data outside answer");
	chk_reading_has_cause:
		assert property (reading_valid |-> $past(conv_valid, 3)) else $error("reading without conversion");
	chk_reading_data_hold:
		assert property (!reading_valid |-> $stable(reading_data)) else $error("reading data moved");
	chk_sweep_drops_conv:
		assert property (sweep_cut |-> ##3 !reading_valid) else $error("conversion kept in sweep flush");
	chk_range_drops_conv:
		assert property (($changed(source_range) || $changed(measure_range)) |-> ##3 !reading_valid)
			else $error("conversion kept in range flush");
	chk_rep_count_span:
		assert property (stat_read |=> reg_rdata[6:0] inside {[`TSF_MIN_COUNT:`TSF_MAX_COUNT]})
			else $error("repeat count out of span");
	chk_rank_span:
		assert property (stat_read |=> reg_rdata[10:8] <= `TSF_MAX_RANK) else $error("rank out of span");
	chk_mov_count_span:
		assert property (stat_read |=> reg_rdata[22:16] inside {[`TSF_MIN_COUNT:`TSF_MAX_COUNT]})
			else $error("moving count out of span");
endmodule

bind tsf_filter tsf_filter_chk chk_i
(
	.clk           (clk),
	.reset         (reset),
	.reg_addr      (reg_addr),
	.reg_rd        (reg_rd),
	.reg_rdata     (reg_rdata),
	.conv_valid    (conv_valid),
	.sweep_active  (sweep_active),
	.source_step   (source_step),
	.source_range  (source_range),
	.measure_range (measure_range),
	.reading_valid (reading_valid),
	.reading_data  (reading_data)
);

`default_nettype wire

/* tsf_stream_model.sv */
// Conversion source and reading sink on the filter's stream side.
// Assumes requests from the bench, changed just after clk edges.
`timescale 1ns/1ps
`default_nettype none

module tsf_stream_model
(
	input  wire logic                  clk,
	input  wire logic                  send,
	input  wire tsf_pkg::tsf_reading_t send_data,
	output logic                       conv_valid,
	output tsf_pkg::tsf_reading_t      conv_data,
	input  wire logic                  reading_valid,
	input  wire tsf_pkg::tsf_reading_t reading_data,
	output int                         got_count,
	output tsf_pkg::tsf_reading_t      got_data
);
	import tsf_pkg::*;

	initial
	begin
		conv_valid = 1'b0;
		conv_data = 32'h0000_0000;
		got_count = 0;
		got_data = 32'h0000_0000;
	end

	// One conversion per request; idle data shows the inverse
	always @(posedge clk)
	begin
		conv_valid <= send;
		conv_data <= send ? send_data : ~conv_data;
		if (reading_valid)
		begin
			got_count <= got_count + 1;
			got_data <= reading_data;
		end
	end
endmodule

`default_nettype wire

/* tsf_filter_test.sv */
// Self-checking bench for the three-stage reading filter.
// Assumes tsf_filter, tsf_stream_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"

module tsf_filter_test;
	import tsf_pkg::*;

	logic         clk, reset, reg_wr, reg_rd, send, sweep_active, source_step;
	logic         conv_valid, reading_valid, range_change_ok;
	logic [7:0]   reg_addr;
	logic [31:0]  reg_wdata, reg_rdata, range_full_scale, rd_v;
	logic [3:0]   source_range, measure_range;
	logic [9:0]   integration_line_cycles;
	logic [9:0]   lc [3];
	tsf_reading_t send_data, conv_data, reading_data, got_data;
	int           got_count, fail_count, checks_done;

	tsf_filter DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
		.conv_data(conv_data), .sweep_active(sweep_active), .source_step(source_step),
		.source_range(source_range), .measure_range(measure_range),
		.range_full_scale(range_full_scale), .integration_line_cycles(integration_line_cycles),
		.reading_valid(reading_valid), .reading_data(reading_data), .range_change_ok(range_change_ok));

	tsf_stream_model model (.clk(clk), .send(send), .send_data(send_data), .conv_valid(conv_valid),
		.conv_data(conv_data), .reading_valid(reading_valid), .reading_data(reading_data),
		.got_count(got_count), .got_data(got_data));

	// -------------------------------------------
	// Helpers
	// -------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Register write, then room for the settings flush
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rd_v = reg_rdata;
	endtask

	// Back-to-back conversions x, x+s, ...
	task burst(input tsf_reading_t x, input tsf_reading_t s, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			send <= 1'b1;
			send_data <= x + s * i;
		end
		@(posedge clk);
		send <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	// Source step; when sweeping, one conversion lands in the step cycle
	task step(input logic sw);
		@(posedge clk);
		send <= sw;
		send_data <= 32'h0000_0400;
		@(posedge clk);
		send <= 1'b0;
		source_step <= 1'b1;
		sweep_active <= sw;
		@(posedge clk);
		source_step <= 1'b0;
		sweep_active <= 1'b0;
	endtask

	// Status word expected from the automatic table
	function logic [31:0] auto_exp(input int t, input int r);
		logic [6:0] rp, mv;
		logic [2:0] rk;
		rp = ((t == 0 && r <= 6) || (t == 1 && r <= 3)) ? 7'h0A : 7'h01;
		rk = r == 0 ? 3'h5 : r == 1 ? 3'h3 : r == 2 ? 3'h1 : 3'h0;
		mv = r == 0 ? 7'h22 : r == 1 ? 7'h0F : r == 2 ? (t == 0 ? 7'h0A : 7'h05) : r == 3 ? 7'h05 : 7'h01;
		return {9'h000, mv, 5'h00, rk, 1'b0, rp};
	endfunction

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test;
	end

	// -------------------------------------------
	// Tests
	// -------------------------------------------
	initial
	begin
		{reset, reg_wr, reg_rd, send, sweep_active, source_step} = 6'b100000;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		send_data = 32'h0000_0000;
		source_range = 4'h0;
		measure_range = 4'h0;
		range_full_scale = 32'h0000_03E8;
		integration_line_cycles = 10'h064;
		lc = '{10'h00A, 10'h064, 10'h065};
		fail_count = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rd(`TSF_OFF_STATUS);
		check(rd_v & 32'h007F_07FF, 32'h0001_0001);
		rd(`TSF_OFF_CTRL);
		check(rd_v, 32'h0000_0000);
		rd(8'h18);
		check(rd_v, 32'h0000_0000);
		check(range_change_ok, 32'h0000_0001);
		burst(32'h0000_1234, 0, 1);
		check(got_data, 32'h0000_1234);
		check(got_count, 1);
		wr(`TSF_OFF_CTRL, 32'h0000_0002);
		wr(`TSF_OFF_REP_COUNT, 32'h0000_0004);
		burst(10, 11, 4);
		check(got_count, 2);
		check(got_data, 26);
		burst(-1, -1, 4);
		check(got_data, -2);
		wr(`TSF_OFF_REP_COUNT, 32'h0000_00C8);
		rd(`TSF_OFF_STATUS);
		check(rd_v[6:0], 7'h64);
		wr(`TSF_OFF_REP_COUNT, 32'h0000_0001);
		burst(77, 0, 1);
		check(got_data, 77);
		wr(`TSF_OFF_CTRL, 32'h0000_0004);
		wr(`TSF_OFF_MED_RANK, 32'h0000_0001);
		check(range_change_ok, 32'h0000_0000);
		burst(7, 93, 2);
		check(got_count, 4);
		burst(3, 0, 1);
		check(got_data, 7);
		check(range_change_ok, 32'h0000_0001);
		burst(50, 0, 1);
		check(got_data, 50);
		wr(`TSF_OFF_MED_RANK, 32'h0000_0009);
		rd(`TSF_OFF_STATUS);
		check(rd_v[10:8], 3'h5);
		wr(`TSF_OFF_CTRL, 32'h0000_0008);
		wr(`TSF_OFF_MOV_COUNT, 32'h0000_0004);
		burst(8, 0, 1);
		check(got_data, 8);
		burst(16, 0, 1);
		check(got_data, 10);
		burst(0, 0, 1);
		check(got_data, 8);
		step(1'b0);
		burst(4, 0, 1);
		check(got_data, 7);
		step(1'b1);
		burst(40, 0, 1);
		check(got_data, 40);
		measure_range <= 4'h1;
		burst(20, 0, 1);
		check(got_data, 20);
		wr(`TSF_OFF_WINDOW, 32'h0000_000A);
		wr(`TSF_OFF_CTRL, 32'h0000_0018);
		burst(500, 50, 2);
		check(got_data, 512);
		burst(800, 0, 1);
		check(got_data, 800);
		wr(`TSF_OFF_CTRL, 32'h0000_0011);
		rd(`TSF_OFF_CTRL);
		check({rd_v[4], rd_v[0]}, 2'b01);
		for (int t = 0; t < 3; t++)
			for (int r = 0; r < 12; r++)
			begin
				@(posedge clk);
				integration_line_cycles <= lc[t];
				measure_range <= r[3:0];
				repeat (3) @(posedge clk);
				rd(`TSF_OFF_STATUS);
				check(rd_v & 32'h007F_07FF, auto_exp(t, r));
			end
		@(posedge clk);
		integration_line_cycles <= 10'h064;
		measure_range <= 4'h1;
		wr(`TSF_OFF_REP_COUNT, 32'h0000_0032);
		rd(`TSF_OFF_STATUS);
		check(rd_v & 32'h007F_07FF, auto_exp(1, 1));
		rd(`TSF_OFF_REP_COUNT);
		check(rd_v, 32'h0000_0001);
		wr(`TSF_OFF_CTRL, 32'h0000_0000);
		measure_range <= 4'h9;
		repeat (3) @(posedge clk);
		rd(`TSF_OFF_STATUS);
		check(rd_v & 32'h007F_07FF, auto_exp(1, 1));
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(`TSF_OFF_STATUS);
		check(rd_v, 32'h0001_0001);
		rd(`TSF_OFF_CTRL);
		check(rd_v, 32'h0000_0000);
		check(reading_data, 32'h0000_0000);
		check(range_change_ok, 32'h0000_0001);
		stop_test;
	end
endmodule

`default_nettype wire
